/* File: verilog/exc_dispatch_pkg.sv */
// How it works
// - machine check, vector 18, is reported as an abort
// - packed simd numeric exception raises vector 19 as a fault, no error code
// - vectors 32 to 255 are interrupt class, external or software
// - request pin accepts any vector 0 to 255
// - local controller accepts only vectors 16 to 255
// - local controller vectors 0 to 15 flag an illegal vector
// - interrupt-enable flag masks pin and local requests as one group
// - software interrupt takes any vector 0 to 255
// - software vector 2 calls nmi handler without nmi blocking
// - software interrupts ignore the interrupt-enable flag
// - software interrupt to an exception vector pushes no error code
// - overflow, breakpoint, bounds instructions raise exceptions; breakpoint is vector 3
// - internal hardware or bus error raises vector 18 with error code
// - a fault rolls machine state back to before the instruction
// - a fault saves the address of the faulting instruction
// - a trap reports after completion, saving the next instruction address
// - abort reports no precise location and forbids restart
// - reset, flush, clock-stop, sys-mgmt, run/stop, init bypass this unit
// - pop-all stack overrun is a fault with pointer restored, registers may change
// - request pin makes the unit fetch the vector from the bus
// - vectors 0 to 31 are reserved for architecture events
// - nmi pin dispatches vector 2
// - with enable flag clear, pin and local requests stay out
package exc_dispatch_pkg;
  localparam logic [7:0] VEC_DIVIDE    = 8'h00;
  localparam logic [7:0] VEC_NMI       = 8'h02;
  localparam logic [7:0] VEC_BREAK     = 8'h03;
  localparam logic [7:0] VEC_OVERFLOW  = 8'h04;
  localparam logic [7:0] VEC_BOUND     = 8'h05;
  localparam logic [7:0] VEC_DOUBLE    = 8'h08;
  localparam logic [7:0] VEC_STACK     = 8'h0C;
  localparam logic [7:0] VEC_MACHCHK   = 8'h12;
  localparam logic [7:0] VEC_SIMD      = 8'h13;
  localparam logic [7:0] VEC_RSV_LO    = 8'h14;
  localparam logic [7:0] VEC_RSV_HI    = 8'h1F;
  localparam logic [7:0] VEC_USER_LO   = 8'h20;
  localparam logic [7:0] VEC_LOCAL_LO  = 8'h10;
  // event class codes
  typedef enum logic [1:0] {
    CLS_FAULT = 2'h0,
    CLS_TRAP  = 2'h1,
    CLS_ABORT = 2'h2,
    CLS_MASKABLE_IRQ_PIN  = 2'h3
  } exc_class_t;
  // software exception instruction kinds
  typedef enum logic [1:0] {
    SWX_NONE  = 2'h0,
    SWX_OVF   = 2'h1,
    SWX_BREAK = 2'h2,
    SWX_BOUND = 2'h3
  } swx_kind_t;
  // vector fetch time-out, in cycles
  localparam int FETCH_WAIT_CYC = 16;
endpackage : exc_dispatch_pkg

/* File: verilog/vector_classify.sv */
`timescale 1ns/100ps
module vector_classify (
  input  wire logic [7:0]                  i_vec,
  input  wire logic                        i_software,
  output exc_dispatch_pkg::exc_class_t     o_cls,
  output logic                             o_err_code
);
  import exc_dispatch_pkg::*;
  // ----------------------------------------------------------------
  // class and error-code lookup
  // ----------------------------------------------------------------
  always_comb begin
    o_err_code = 1'b0;
    if (i_vec >= VEC_USER_LO) begin
      o_cls = CLS_MASKABLE_IRQ_PIN;
    end else begin
      unique case (i_vec)
        VEC_NMI:                     o_cls = CLS_MASKABLE_IRQ_PIN;
        VEC_BREAK, VEC_OVERFLOW:     o_cls = CLS_TRAP;
        VEC_DOUBLE, VEC_MACHCHK:     o_cls = CLS_ABORT;
        default:                     o_cls = CLS_FAULT;
      endcase
      // hardware exceptions that push a code; software never does
      if (!i_software) begin
        o_err_code = (i_vec == VEC_DOUBLE) ||
                     ((i_vec >= 8'h0A) && (i_vec <= 8'h0E)) ||
                     (i_vec == 8'h11) || (i_vec == VEC_MACHCHK);
      end
    end
  end
endmodule : vector_classify

/* File: verilog/sync_2ff.sv */
`timescale 1ns/100ps
module sync_2ff (
  input  wire logic i_core_clk,
  input  wire logic i_rstn,
  input  wire logic i_async,
  output logic      o_sync
);
  // ----------------------------------------------------------------
  // two-stage synchroniser; first stage read only by the second
  // ----------------------------------------------------------------
  typedef struct packed {
    logic meta;
    logic sync;
  } sync_state_t;
  sync_state_t st;
  sync_state_t next_st;
  always_comb begin
    next_st.meta = i_async;
    next_st.sync = st.meta;
  end
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_sync = st.sync;
endmodule : sync_2ff

/* File: verilog/exception_vector_dispatch.sv */
`timescale 1ns/100ps
module exception_vector_dispatch (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rstn,
  // core side
  input  wire logic                        i_boundary,
  input  wire logic                        i_if_flag,
  input  wire logic [31:0]                 i_cur_ip,
  input  wire logic [31:0]                 i_next_ip,
  input  wire logic                        i_fault_req,
  input  wire logic [7:0]                  i_fault_vec,
  input  wire logic                        i_simd_float_exc,
  input  wire logic                        i_popall_overrun,
  input  wire logic                        i_hw_error,
  input  wire logic                        i_bus_error,
  input  wire logic                        i_swint_req,
  input  wire logic [7:0]                  i_swint_vec,
  input  wire exc_dispatch_pkg::swx_kind_t i_swx_kind,
  input  wire logic                        i_nmi_done,
  // pins and local controller
  input  wire logic                        i_nmi_pin,
  input  wire logic                        i_maskable_irq_pin,
  input  wire logic                        i_bus_vec_valid,
  input  wire logic [7:0]                  i_bus_vec,
  input  wire logic                        i_local_irq_valid,
  input  wire logic [7:0]                  i_local_irq_vec,
  // dispatch outputs
  output logic                             o_dispatch,
  output logic [7:0]                       o_vec,
  output exc_dispatch_pkg::exc_class_t     o_cls,
  output logic                             o_err_code,
  output logic [31:0]                      o_ret_ip,
  output logic                             o_rollback,
  output logic                             o_restartable,
  output logic                             o_regs_dirty,
  output logic                             o_nmi_blocked,
  output logic                             o_vec_fetch,
  output logic                             o_local_irq_ack,
  output logic                             o_illegal_vec,
  output logic                             o_machine_check_exc
);
  import exc_dispatch_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FS_IDLE  = 2'b01,
    FS_FETCH = 2'b10
  } fetch_state_t;

  typedef struct packed {
    fetch_state_t fs;
    logic [4:0]   wait_cnt;
    logic         irq_vec_ok;
    logic [7:0]   irq_vec;
    logic         nmi_prev;
    logic         nmi_pend;
    logic         nmi_blocked;
    logic         mc_pend;
    logic         dispatch;
    logic [7:0]   vec;
    exc_class_t   cls;
    logic         err_code;
    logic [31:0]  ret_ip;
    logic         rollback;
    logic         restartable;
    logic         regs_dirty;
    logic         ack;
    logic         illegal;
    logic         mc_out;
  } disp_state_t;

  disp_state_t st;
  disp_state_t next_st;

  logic       nmi_s;
  logic       irq_s;
  logic [7:0] sel_vec;
  logic       sel_sw;
  logic       sel_any;
  exc_class_t sel_cls;
  logic       sel_err;
  logic       sel_irq;
  exc_class_t eff_cls;
  logic       eff_err;
  logic       local_take;

  // pins come from outside the clock domain
  sync_2ff u_sync_nmi (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_async    (i_nmi_pin),
    .o_sync     (nmi_s)
  );
  sync_2ff u_sync_irq (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_async    (i_maskable_irq_pin),
    .o_sync     (irq_s)
  );

  vector_classify u_cls (
    .i_vec      (sel_vec),
    .i_software (sel_sw),
    .o_cls      (sel_cls),
    .o_err_code (sel_err)
  );

  // a maskable request is an interrupt whatever its vector: no fault rollback, no code push
  assign eff_cls = sel_irq ? CLS_MASKABLE_IRQ_PIN : sel_cls;
  assign eff_err = sel_err && !sel_irq;

  // ----------------------------------------------------------------
  // priority select: one winner per boundary
  // ----------------------------------------------------------------
  // order: machine check, instruction fault, nmi, maskable irq, software
  // special pins (reset, flush, clock-stop, ...) never reach this select
  always_comb begin
    sel_vec = VEC_DIVIDE;
    sel_sw  = 1'b0;
    sel_irq = 1'b0;
    sel_any = 1'b1;
    if (st.mc_pend || i_hw_error || i_bus_error) begin
      sel_vec = VEC_MACHCHK;
    end else if (i_popall_overrun) begin
      sel_vec = VEC_STACK;
    end else if (i_simd_float_exc) begin
      sel_vec = VEC_SIMD;
    end else if (i_fault_req) begin
      sel_vec = i_fault_vec;
    end else if (st.nmi_pend && !st.nmi_blocked) begin
      sel_vec = VEC_NMI;
    end else if (i_if_flag && st.irq_vec_ok) begin
      sel_vec = st.irq_vec;
      sel_irq = 1'b1;
    end else if (i_swx_kind != SWX_NONE) begin
      unique case (i_swx_kind)
        SWX_OVF:   sel_vec = VEC_OVERFLOW;
        SWX_BREAK: sel_vec = VEC_BREAK;
        default:   sel_vec = VEC_BOUND;
      endcase
    end else if (i_swint_req) begin
      sel_vec = i_swint_vec;
      sel_sw  = 1'b1;
    end else begin
      sel_any = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.dispatch = 1'b0;
    next_st.ack      = 1'b0;
    next_st.illegal  = 1'b0;
    next_st.mc_out   = 1'b0;
    next_st.nmi_prev = nmi_s;
    // nmi is edge triggered; a new edge wins over a take
    if (nmi_s && !st.nmi_prev) begin
      next_st.nmi_pend = 1'b1;
    end
    if (i_hw_error || i_bus_error) begin
      next_st.mc_pend = 1'b1;
    end
    if (i_nmi_done) begin
      next_st.nmi_blocked = 1'b0;
    end
    // maskable pin: fetch vector over the bus; local controller: take its vector directly
    unique case (st.fs)
      FS_IDLE: begin
        if (irq_s && i_if_flag && !st.irq_vec_ok) begin
          next_st.fs       = FS_FETCH;
          next_st.wait_cnt = '0;
        end else if (i_local_irq_valid && i_if_flag && !st.irq_vec_ok) begin
          next_st.ack = 1'b1;
          if (i_local_irq_vec < VEC_LOCAL_LO) begin
            next_st.illegal = 1'b1;
          end else begin
            next_st.irq_vec_ok = 1'b1;
            next_st.irq_vec    = i_local_irq_vec;
          end
        end
      end
      FS_FETCH: begin
        if (i_bus_vec_valid) begin
          next_st.irq_vec_ok = 1'b1;
          next_st.irq_vec    = i_bus_vec;
          next_st.fs         = FS_IDLE;
        end else if (st.wait_cnt == 5'(FETCH_WAIT_CYC - 1)) begin
          next_st.fs = FS_IDLE;                           // spurious request dropped
        end else begin
          next_st.wait_cnt = st.wait_cnt + 5'h01;
        end
      end
    endcase
    // dispatch at an instruction boundary
    if (i_boundary && sel_any) begin
      next_st.dispatch    = 1'b1;
      next_st.vec         = sel_vec;
      next_st.cls         = eff_cls;
      next_st.err_code    = eff_err;
      next_st.rollback    = (eff_cls == CLS_FAULT);
      next_st.restartable = (eff_cls != CLS_ABORT);
      next_st.regs_dirty  = (sel_vec == VEC_STACK) && i_popall_overrun && !sel_sw;
      // fault returns to itself, trap and interrupt to the successor, abort to zero
      next_st.ret_ip = (eff_cls == CLS_FAULT) ? i_cur_ip : i_next_ip;
      if (eff_cls == CLS_ABORT) begin
        next_st.ret_ip = '0;
      end
      // a maskable vector of 18 is only an interrupt, not a machine check
      if (sel_vec == VEC_MACHCHK && !sel_sw && !sel_irq) begin
        next_st.mc_pend = i_hw_error || i_bus_error;
        next_st.mc_out  = 1'b1;
      end else if (sel_vec == VEC_NMI && !sel_sw && st.nmi_pend && !st.nmi_blocked) begin
        next_st.nmi_pend    = nmi_s && !st.nmi_prev;
        next_st.nmi_blocked = 1'b1;
      end else if (sel_irq) begin
        next_st.irq_vec_ok = 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st    <= '0;
      st.fs <= FS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_dispatch          = st.dispatch;
  assign o_vec               = st.vec;
  assign o_cls               = st.cls;
  assign o_err_code          = st.err_code;
  assign o_ret_ip            = st.ret_ip;
  assign o_rollback          = st.rollback;
  assign o_restartable       = st.restartable;
  assign o_regs_dirty        = st.regs_dirty;
  assign o_nmi_blocked       = st.nmi_blocked;
  assign o_vec_fetch         = (st.fs == FS_FETCH);
  assign o_local_irq_ack     = st.ack;
  assign o_illegal_vec       = st.illegal;
  assign o_machine_check_exc = st.mc_out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_hw_err;
    i_hw_error || i_bus_error;
  endsequence
  sequence s_mc_out;
    o_dispatch && o_vec == VEC_MACHCHK && o_err_code;
  endsequence
  property p_mc_class;
    @(posedge i_core_clk) disable iff (!i_rstn)
    o_dispatch && o_vec == VEC_MACHCHK |-> o_cls == CLS_ABORT && !o_restartable;
  endproperty
  a_mc_class: assert property (p_mc_class) else $error("machine check not abort");
  property p_mc_err;
    @(posedge i_core_clk) disable iff (!i_rstn)
    s_hw_err ##0 i_boundary |=> s_mc_out;
  endproperty
  a_mc_err: assert property (p_mc_err) else $error("hw error not dispatched");
  property p_simd;
    @(posedge i_core_clk) disable iff (!i_rstn)
    o_dispatch && o_vec == VEC_SIMD |-> o_cls == CLS_FAULT && !o_err_code;
  endproperty
  a_simd: assert property (p_simd) else $error("simd class wrong");
  property p_user_maskable_irq_pin;
    @(posedge i_core_clk) disable iff (!i_rstn)
    o_dispatch && o_vec >= VEC_USER_LO |-> o_cls == CLS_MASKABLE_IRQ_PIN;
  endproperty
  a_user_maskable_irq_pin: assert property (p_user_maskable_irq_pin) else $error("user vector not interrupt");
  property p_illegal;
    @(posedge i_core_clk) disable iff (!i_rstn)
    local_take && i_local_irq_vec < VEC_LOCAL_LO |=> o_illegal_vec;
  endproperty
  assign local_take = st.fs == FS_IDLE && !irq_s && i_local_irq_valid
                      && i_if_flag && !st.irq_vec_ok;
  a_illegal: assert property (p_illegal) else $error("illegal vector not flagged");
  property p_mask;
    @(posedge i_core_clk) disable iff (!i_rstn)
    !i_if_flag && !st.irq_vec_ok |=> !st.irq_vec_ok;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request accepted");
  property p_sw_noerr;
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_boundary && sel_sw |=> o_dispatch && !o_err_code && o_vec == $past(i_swint_vec);
  endproperty
  a_sw_noerr: assert property (p_sw_noerr) else $error("software push of error code");
  property p_sw_nmi;
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_boundary && sel_sw && !o_nmi_blocked && !i_nmi_done |=> !o_nmi_blocked;
  endproperty
  a_sw_nmi: assert property (p_sw_nmi) else $error("software nmi engaged block");
  property p_fault_ip;
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_boundary && sel_any && eff_cls == CLS_FAULT |=> o_ret_ip == $past(i_cur_ip) && o_rollback;
  endproperty
  a_fault_ip: assert property (p_fault_ip) else $error("fault return address wrong");
  property p_trap_ip;
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_boundary && sel_any && eff_cls == CLS_TRAP |=> o_ret_ip == $past(i_next_ip);
  endproperty
  a_trap_ip: assert property (p_trap_ip) else $error("trap return address wrong");
  property p_fetch_bound;
    @(posedge i_core_clk) disable iff (!i_rstn)
    $rose(o_vec_fetch) |-> ##[1:16] !o_vec_fetch;
  endproperty
  a_fetch_bound: assert property (p_fetch_bound) else $error("vector fetch hung");
endmodule : exception_vector_dispatch

/* File: verification/irq_source_model.sv */
`timescale 1ns/100ps
module irq_source_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_req,
  input  wire logic [7:0] i_req_vec,
  input  wire logic [3:0] i_delay,
  input  wire logic       i_vec_fetch,
  output logic            o_irq_pin,
  output logic            o_vec_valid,
  output logic [7:0]      o_vec
);
  // ------------------------------
  // external controller behaviour
  // ------------------------------
  logic [7:0] held;
  logic [3:0] cnt;

  // pin stays up until the fetch is answered; an idle bus toggles so no stale vector is read
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq_pin   <= 1'b0;
      o_vec_valid <= 1'b0;
      o_vec       <= 8'h00;
      held        <= 8'h00;
      cnt         <= 4'h0;
    end else begin
      o_vec_valid <= 1'b0;
      o_vec       <= ~o_vec;
      if (i_req) begin
        o_irq_pin <= 1'b1;
        held      <= i_req_vec;
        cnt       <= 4'h0;
      end else if (o_irq_pin && i_vec_fetch) begin
        cnt <= cnt + 4'h1;
        if (cnt == i_delay) begin
          o_vec_valid <= 1'b1;
          o_vec       <= held;
          o_irq_pin   <= 1'b0;
        end
      end
    end
  end
endmodule : irq_source_model

/* File: verification/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import exc_dispatch_pkg::*;
  // ------------------------------
  // signals and design
  // ------------------------------
  logic        core_clk, rstn, bnd, if_flag, f_req, simd, popall, hw_err, bus_err;
  logic        swint, nmi_done, nmi, l_valid, src_req, irq_pin, b_valid;
  logic [7:0]  f_vec, sw_vec, l_vec, src_vec, b_vec, vec;
  logic [3:0]  src_dly;
  logic [31:0] cur_ip, nxt_ip, ret_ip;
  swx_kind_t   swx;
  exc_class_t  cls;
  logic        disp, err, rollb, restart, dirty, nmi_blk, fetch, l_ack, illeg, mc;
  int          miscompares, tests_run;
  int          pend_q[$];
  int          sw_tab[6] = '{14, 2, 8, 3, 255, 32};

  always #4 core_clk = ~core_clk;

  exception_vector_dispatch exception_vector_dispatch_i (
    .i_core_clk(core_clk), .i_rstn(rstn), .i_boundary(bnd), .i_if_flag(if_flag),
    .i_cur_ip(cur_ip), .i_next_ip(nxt_ip), .i_fault_req(f_req), .i_fault_vec(f_vec),
    .i_simd_float_exc(simd), .i_popall_overrun(popall), .i_hw_error(hw_err),
    .i_bus_error(bus_err), .i_swint_req(swint), .i_swint_vec(sw_vec), .i_swx_kind(swx),
    .i_nmi_done(nmi_done), .i_nmi_pin(nmi), .i_maskable_irq_pin(irq_pin),
    .i_bus_vec_valid(b_valid), .i_bus_vec(b_vec), .i_local_irq_valid(l_valid),
    .i_local_irq_vec(l_vec), .o_dispatch(disp), .o_vec(vec), .o_cls(cls),
    .o_err_code(err), .o_ret_ip(ret_ip), .o_rollback(rollb), .o_restartable(restart),
    .o_regs_dirty(dirty), .o_nmi_blocked(nmi_blk), .o_vec_fetch(fetch),
    .o_local_irq_ack(l_ack), .o_illegal_vec(illeg), .o_machine_check_exc(mc));

  irq_source_model irq_source_model_i (
    .i_core_clk(core_clk), .i_rstn(rstn), .i_req(src_req), .i_req_vec(src_vec),
    .i_delay(src_dly), .i_vec_fetch(fetch), .o_irq_pin(irq_pin), .o_vec_valid(b_valid),
    .o_vec(b_vec));

  // ------------------------------
  // model, checks and drivers
  // ------------------------------
  // class of an exception vector; user vectors and vector 2 are interrupts
  function automatic int cls_of(input int v);
    if (v >= 32 || v == 2) return 3;
    if (v == 3 || v == 4) return 1;
    if (v == 8 || v == 18) return 2;
    return 0;
  endfunction : cls_of

  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %0h seen %0h", name, e, g);
    end
  endtask : check

  task automatic end_sim();
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  // boundary with the oldest expected event; called at a rising edge
  task automatic take(input logic e, input logic hw_int);
    int          v, c;
    logic [31:0] ci, ni, rip;
    v = pend_q.pop_front();
    c = hw_int ? 3 : cls_of(v);
    ci = $urandom;
    ni = ci + 32'($urandom_range(15, 1));
    rip = (c == 0) ? ci : (c == 2) ? 32'h0 : ni;
    bnd    <= 1'b1;
    cur_ip <= ci;
    nxt_ip <= ni;
    @(posedge core_clk);
    bnd   <= 1'b0;
    f_req <= 1'b0;
    simd  <= 1'b0;
    popall <= 1'b0;
    swint <= 1'b0;
    swx   <= SWX_NONE;
    {hw_err, bus_err} <= 2'b00;
    #1;
    check("dispatch", 1, disp);
    check("rollback", (c == 0) ? 1 : 0, rollb);
    check("restartable", (c != 2) ? 1 : 0, restart);
    check("vector", v, vec);
    check("class", c, cls);
    check("error code", e, err);
    check("return ip", rip, ret_ip);
  endtask : take

  task automatic idle();
    @(posedge core_clk);
    bnd <= 1'b1;
    @(posedge core_clk);
    bnd <= 1'b0;
    #1;
    check("no dispatch", 0, disp);
  endtask : idle

  task automatic wait_fetch(input logic lvl);
    int n;
    n = 0;
    while (fetch !== lvl) begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > 40) begin
        miscompares++;
        end_sim();
      end
    end
  endtask : wait_fetch

  task automatic local_irq(input logic [7:0] v, input logic ie, input logic a, input logic il);
    @(posedge core_clk);
    if_flag <= ie;
    l_valid <= 1'b1;
    l_vec   <= v;
    @(posedge core_clk);
    l_valid <= 1'b0;
    l_vec   <= ~v;                    // released line must not keep the vector
    #1;
    check("local ack", a, l_ack);
    check("illegal", il, illeg);
  endtask : local_irq

  task automatic pin_irq(input logic [7:0] v, input logic ie);
    @(posedge core_clk);
    if_flag <= ie;
    src_req <= 1'b1;
    src_vec <= v;
    src_dly <= 4'($urandom_range(5));
    @(posedge core_clk);
    src_req <= 1'b0;
    if (!ie) begin
      repeat (8) @(posedge core_clk);
      #1;
      check("fetch", 0, fetch);
      idle();
      @(posedge core_clk);
      if_flag <= 1'b1;
    end
    wait_fetch(1'b1);
    wait_fetch(1'b0);
    repeat (4) @(posedge core_clk);
    pend_q.push_back(v);
    take(1'b0, 1'b1);
  endtask : pin_irq

  // ------------------------------
  // scenarios
  // ------------------------------
  initial begin
    {core_clk, rstn, bnd, if_flag, f_req, simd, popall, hw_err, bus_err} = '0;
    {swint, nmi_done, nmi, l_valid, src_req, f_vec, sw_vec, l_vec, src_vec} = '0;
    {src_dly, cur_ip, nxt_ip} = '0;
    swx = SWX_NONE;
    miscompares = 0;
    tests_run = 0;
    void'($urandom(89));
    sw_tab[5] = $urandom_range(255, 32);
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    // software interrupts with the enable flag clear
    foreach (sw_tab[k]) begin
      @(posedge core_clk);
      swint  <= 1'b1;
      sw_vec <= 8'(sw_tab[k]);
      pend_q.push_back(sw_tab[k]);
      take(1'b0, 1'b0);
      if (sw_tab[k] == 2) check("nmi blocked", 0, nmi_blk);
    end
    // overflow, breakpoint and bounds instructions
    for (int k = 1; k < 4; k++) begin
      @(posedge core_clk);
      swx <= swx_kind_t'(k);
      pend_q.push_back((k == 1) ? 4 : (k == 2) ? 3 : 5);
      take(1'b0, 1'b0);
    end
    @(posedge core_clk);
    simd <= 1'b1;
    pend_q.push_back(19);
    take(1'b0, 1'b0);
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      f_req <= 1'b1;
      f_vec <= k ? 8'h0E : 8'h00;
      pend_q.push_back(k ? 14 : 0);
      take(1'(k), 1'b0);
      check("rollback", 1, rollb);
    end
    @(posedge core_clk);
    popall <= 1'b1;
    pend_q.push_back(12);
    take(1'b1, 1'b0);
    check("regs dirty", 1, dirty);
    // machine check wins over a software interrupt at the same boundary
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      if (k == 0) hw_err <= 1'b1;
      else bus_err <= 1'b1;
      swint  <= 1'b1;
      sw_vec <= 8'h40;
      // k=1 holds the bus error into the boundary itself
      if (k == 0) begin
        @(posedge core_clk);
        hw_err <= 1'b0;
      end
      pend_q.push_back(18);
      take(1'b1, 1'b0);
      check("machine check", 1, mc);
      check("restartable", 0, restart);
      if (k == 1) begin
        // the error seen at the dispatch edge latches again: the set wins
        pend_q.push_back(18);
        @(posedge core_clk);
        take(1'b1, 1'b0);
        check("machine check", 1, mc);
      end
      idle();
    end
    // second nmi waits for the handler to return
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      nmi <= 1'b1;
      repeat (4) @(posedge core_clk);
      nmi <= 1'b0;
      if (k == 1) begin
        idle();
        @(posedge core_clk);
        nmi_done <= 1'b1;
        @(posedge core_clk);
        nmi_done <= 1'b0;
      end
      pend_q.push_back(2);
      take(1'b0, 1'b0);
      check("nmi blocked", 1, nmi_blk);
    end
    local_irq(8'h0F, 1'b1, 1'b1, 1'b1);
    idle();
    local_irq(8'h10, 1'b1, 1'b1, 1'b0);
    pend_q.push_back(16);
    @(posedge core_clk);
    take(1'b0, 1'b1);
    local_irq(8'($urandom_range(255, 32)), 1'b0, 1'b0, 1'b0);
    pin_irq(8'h0E, 1'b1);
    pin_irq(8'($urandom_range(255, 32)), 1'b0);
    end_sim();
  end
endmodule : testbench
